/* hw/bhg_pkg.sv */
// Package of constants and carrier types for the bus hold grant block
package bhg_pkg;
  // ==========================================================================
  // Reset values and counts
  // ==========================================================================
  localparam logic       GRANT_N_RESET   = 1'b1;
  localparam logic       FLOAT_RESET     = 1'b0;
  localparam logic [1:0] FLOAT_DELAY_CYC = 2'h1;
  localparam logic [1:0] RESUME_DELAY_CYC = 2'h1;

  // ==========================================================================
  // Hold sequence states
  // ==========================================================================
  typedef enum logic [2:0] {
    BHG_RUN       = 3'b000,
    BHG_GRANT     = 3'b001,
    BHG_HOLD      = 3'b010,
    BHG_UNGRANT   = 3'b011,
    BHG_RESUME    = 3'b100
  } bhg_state_type;

  // ==========================================================================
  // Bus activity reported by the CPU bus unit
  // ==========================================================================
  typedef struct packed {
    logic cycle_active;   // A bus cycle is in progress
    logic cycle_last;     // This bus clock is the last of the cycle
    logic split_first;    // First half of an odd-address word access
  } bhg_bus_status_type;

  // ==========================================================================
  // Hold control outputs
  // ==========================================================================
  typedef struct packed {
    logic cpu_clk_stop;   // CPU clock gated off
    logic bus_float;      // Address/data, R/W and byte-high enable released
    logic watchdog_halt;  // Watchdog timer halted
    logic addr_repeat;    // Re-drive previous address on resume
  } bhg_ctrl_type;
endpackage : bhg_pkg

/* hw/bhg_sync.sv */
// Two flip-flop synchroniser for the request pin
`timescale 1ns/1ps
`default_nettype none
module bhg_sync #(
  parameter logic RESET_VAL = 1'b1
) (
  input  wire logic clk_in,    // Clock
  input  wire logic rst_in,    // Synchronous reset, active high
  input  wire logic d_in,      // Asynchronous level
  output var  logic q_out      // Synchronised level
);
  logic meta_reg;

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      meta_reg <= RESET_VAL;
      q_out    <= RESET_VAL;
    end else begin
      meta_reg <= d_in;
      q_out    <= meta_reg;
    end
  end
endmodule // bhg_sync
`default_nettype wire

/* hw/bhg_sample.sv */
// Request sampling qualifier: decides on which bus clock a sample is taken
`timescale 1ns/1ps
`default_nettype none
module bhg_sample (
  input  wire logic                        bus_clk_en_in,  // Bus clock runs this cycle
  input  wire logic                        in_hold_in,     // Hold sequence active
  input  wire bhg_pkg::bhg_bus_status_type bus_in,         // Bus activity
  output logic                             sample_out      // Take a sample this cycle
);
  always_comb begin
    sample_out = 1'b0;
    if (!bus_clk_en_in) begin
      sample_out = 1'b0;
    end else if (in_hold_in) begin
      sample_out = 1'b1;
    end else if (!bus_in.cycle_active) begin
      sample_out = 1'b1;
    end else begin
      sample_out = bus_in.cycle_last && !bus_in.split_first;
    end
  end
endmodule // bhg_sample
`default_nettype wire

/* hw/bhg_top.sv */
// Bus hold logic: request sampling, grant output and bus release sequencing
// How it works
// - With no bus cycle running, the request is sampled on every bus clock.
// - During a bus cycle, the request is sampled only on the last clock of that cycle.
// - An odd-address word done as two bus cycles is sampled only at the end of the second.
// - A sample that finds the request low accepts it and starts the hold.
// - On acceptance the CPU clock stops and the grant goes low on the next rising edge.
// - One bus clock after the grant falls, R/W, byte-high enable and the bus float.
// - In hold, the request is sampled on every bus clock.
// - A hold sample that finds the request high raises the grant on the next rising edge.
// - One bus clock after the grant rises, CPU clocking and bus driving resume.
// - The bus clock pauses in Ready, stop and wait, so no sampling happens then.
// - The sampling clock matches the visible reference clock in rate and polarity.
// - A request taken at the end of a bus cycle makes the device re-drive the last address.
// - No request is taken until a whole 16-bit word transfer has finished.
// - In hold the peripherals keep running but the watchdog timer is halted.
`timescale 1ns/1ps
`default_nettype none
module bhg_top (
  input  wire logic                        ref_clk_in,         // 40 MHz reference clock
  input  wire logic                        rst_in,             // Synchronous reset, active high
  input  wire logic                        bus_request_n_in,   // Bus request pin, active low
  input  wire logic                        ready_state_in,     // Ready state in force
  input  wire logic                        stop_instruction_in, // Stop instruction executed
  input  wire logic                        wait_instruction_in, // Wait instruction executed
  input  wire bhg_pkg::bhg_bus_status_type bus_status_in,      // Bus activity from bus unit
  output logic                             bus_clk_en_out,     // Bus clock running this cycle
  output var  logic                        bus_grant_n_out,    // Bus grant pin, active low
  output var  bhg_pkg::bhg_ctrl_type       ctrl_out,           // Hold control to CPU and pads
  output logic                             rw_oe_out,          // R/W pin output enable
  output logic                             byte_high_enable_n_oe_out, // Byte-high enable output enable
  output logic                             addr_data_oe_out    // Address/data bus output enable
);
  // ==========================================================================
  // Request pin synchroniser
  // ==========================================================================
  logic req_n_sync;

  bhg_sync #(
    .RESET_VAL (1'b1)
  ) u_sync (
    .clk_in (ref_clk_in),
    .rst_in (rst_in),
    .d_in   (bus_request_n_in),
    .q_out  (req_n_sync)
  );

  // ==========================================================================
  // Bus clock enable: same rate and phase as the reference clock, gated by pauses
  // ==========================================================================
  always_comb begin
    bus_clk_en_out = !(ready_state_in || stop_instruction_in || wait_instruction_in);
  end

  // ==========================================================================
  // State decode shared by the sequencer and the output registers
  // ==========================================================================
  function automatic logic grant_active(input bhg_pkg::bhg_state_type st);
    return (st == bhg_pkg::BHG_GRANT) || (st == bhg_pkg::BHG_HOLD);
  endfunction

  function automatic logic cpu_halted(input bhg_pkg::bhg_state_type st);
    return (st != bhg_pkg::BHG_RUN);
  endfunction

  // Float from the settled hold through the one clock after the grant rises
  function automatic logic bus_released(input bhg_pkg::bhg_state_type st,
                                        input logic                   floating);
    return (st == bhg_pkg::BHG_HOLD) || ((st == bhg_pkg::BHG_UNGRANT) && floating);
  endfunction

  // ==========================================================================
  // Sample qualification
  // ==========================================================================
  bhg_pkg::bhg_state_type state_reg;
  bhg_pkg::bhg_state_type state_next;
  logic                   in_hold;
  logic                   sample;

  always_comb begin
    in_hold = cpu_halted(state_reg);
  end

  bhg_sample u_sample (
    .bus_clk_en_in (bus_clk_en_out),
    .in_hold_in    (in_hold),
    .bus_in        (bus_status_in),
    .sample_out    (sample)
  );

  // ==========================================================================
  // Hold sequencer
  // ==========================================================================
  logic [1:0] delay_reg;
  logic [1:0] delay_next;
  logic       accept_seen;
  logic       release_seen;

  always_comb begin
    accept_seen  = sample && !req_n_sync;
    release_seen = sample && req_n_sync;
  end

  always_comb begin
    state_next = state_reg;
    delay_next = delay_reg;
    case (state_reg)
      bhg_pkg::BHG_RUN: begin
        if (accept_seen) begin
          state_next = bhg_pkg::BHG_GRANT;
          delay_next = bhg_pkg::FLOAT_DELAY_CYC;
        end
      end
      bhg_pkg::BHG_GRANT: begin
        if (release_seen) begin
          state_next = bhg_pkg::BHG_UNGRANT;
          delay_next = bhg_pkg::RESUME_DELAY_CYC;
        end else if (bus_clk_en_out) begin
          if (delay_reg <= 2'h1) begin
            state_next = bhg_pkg::BHG_HOLD;
          end else begin
            delay_next = delay_reg - 2'h1;
          end
        end
      end
      bhg_pkg::BHG_HOLD: begin
        if (release_seen) begin
          state_next = bhg_pkg::BHG_UNGRANT;
          delay_next = bhg_pkg::RESUME_DELAY_CYC;
        end
      end
      bhg_pkg::BHG_UNGRANT: begin
        if (bus_clk_en_out) begin
          if (delay_reg <= 2'h1) begin
            state_next = bhg_pkg::BHG_RUN;
          end else begin
            delay_next = delay_reg - 2'h1;
          end
        end
      end
      default: begin
        state_next = bhg_pkg::BHG_RUN;
        delay_next = 2'h0;
      end
    endcase
  end

  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      state_reg <= bhg_pkg::BHG_RUN;
    end else begin
      state_reg <= state_next;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      delay_reg <= 2'h0;
    end else begin
      delay_reg <= delay_next;
    end
  end

  // ==========================================================================
  // Grant pin
  // ==========================================================================
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      bus_grant_n_out <= bhg_pkg::GRANT_N_RESET;
    end else begin
      bus_grant_n_out <= !grant_active(state_next);
    end
  end

  // ==========================================================================
  // Control outputs: clock stop, float, watchdog halt, address repeat
  // ==========================================================================
  logic accepted_in_cycle;

  always_comb begin
    accepted_in_cycle = (state_reg == bhg_pkg::BHG_RUN) && (state_next == bhg_pkg::BHG_GRANT) &&
                        bus_status_in.cycle_active;
  end

  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      ctrl_out.cpu_clk_stop  <= 1'b0;
      ctrl_out.watchdog_halt <= 1'b0;
    end else begin
      ctrl_out.cpu_clk_stop  <= cpu_halted(state_next);
      ctrl_out.watchdog_halt <= cpu_halted(state_next);
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      ctrl_out.bus_float <= bhg_pkg::FLOAT_RESET;
    end else begin
      ctrl_out.bus_float <= bus_released(state_next, ctrl_out.bus_float);
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      ctrl_out.addr_repeat <= 1'b0;
    end else if (accepted_in_cycle) begin
      ctrl_out.addr_repeat <= 1'b1;
    end else if ((state_reg == bhg_pkg::BHG_RUN) && bus_clk_en_out && !in_hold) begin
      ctrl_out.addr_repeat <= 1'b0;
    end
  end

  // ==========================================================================
  // Pad output enables, high while driving
  // ==========================================================================
  localparam int PAD_GROUPS = 3;

  logic [PAD_GROUPS-1:0] pad_oe;

  for (genvar pad_idx = 0; pad_idx < PAD_GROUPS; pad_idx++) begin : g_pad_oe
    assign pad_oe[pad_idx] = !ctrl_out.bus_float;
  end

  always_comb begin
    rw_oe_out                 = pad_oe[0];
    byte_high_enable_n_oe_out = pad_oe[1];
    addr_data_oe_out          = pad_oe[2];
  end
endmodule // bhg_top
`default_nettype wire

/* test/bhg_monitor.sv */
// Concurrent checker for the bus hold grant block
`timescale 1ns/1ps
`default_nettype none
module bhg_monitor (
  input wire logic                        ref_clk_in,                // Clock
  input wire logic                        rst_in,                    // Reset
  input wire logic                        bus_request_n_in,          // Request pin
  input wire logic                        ready_state_in,            // Ready state
  input wire logic                        stop_instruction_in,       // Stop executed
  input wire logic                        wait_instruction_in,       // Wait executed
  input wire bhg_pkg::bhg_bus_status_type bus_status_in,             // Bus activity
  input wire logic                        bus_clk_en_out,            // Bus clock runs
  input wire logic                        bus_grant_n_out,           // Grant pin
  input wire bhg_pkg::bhg_ctrl_type       ctrl_out,                  // Hold control
  input wire logic                        rw_oe_out,                 // R/W enable
  input wire logic                        byte_high_enable_n_oe_out, // Byte-high enable
  input wire logic                        addr_data_oe_out           // Bus enable
);
  // ==========================================================================
  // Request as the block sees it after two flops
  // ==========================================================================
  logic req_d1_reg;
  logic req_d2_reg;
  always_ff @(posedge ref_clk_in) begin
    req_d1_reg <= rst_in ? 1'h1 : bus_request_n_in;
    req_d2_reg <= rst_in ? 1'h1 : req_d1_reg;
  end
  wire logic run_w  = bus_grant_n_out && !ctrl_out.cpu_clk_stop;
  wire logic slot_w = bus_clk_en_out && (!bus_status_in.cycle_active
                      || (bus_status_in.cycle_last && !bus_status_in.split_first));
  // ==========================================================================
  // Properties
  // ==========================================================================
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (rst_in);
  sequence float_step;
    !ctrl_out.bus_float ##1 ctrl_out.bus_float;
  endsequence
  sequence resume_step;
    ctrl_out.cpu_clk_stop ##1 !ctrl_out.cpu_clk_stop;
  endsequence
  sequence release_step;
    ctrl_out.bus_float ##1 !ctrl_out.bus_float;
  endsequence
  chk_float_release: assert property ($rose(bus_grant_n_out) && bus_clk_en_out && $past(ctrl_out.bus_float)
    |-> release_step) else $error("float release wrong");
  chk_accept_grant: assert property (run_w && slot_w && !req_d2_reg |=>
    !bus_grant_n_out && ctrl_out.cpu_clk_stop) else $error("grant missing");
  chk_refuse_busy: assert property (run_w && !(slot_w && !req_d2_reg) |=>
    bus_grant_n_out) else $error("grant out of slot");
  chk_float_delay: assert property ($fell(bus_grant_n_out) && bus_clk_en_out && !req_d2_reg
    |-> float_step) else $error("float delay wrong");
  chk_oe_float: assert property ((rw_oe_out == !ctrl_out.bus_float)
    && (byte_high_enable_n_oe_out == !ctrl_out.bus_float) && (addr_data_oe_out == !ctrl_out.bus_float))
    else $error("enable mismatch");
  chk_hold_sample: assert property (!bus_grant_n_out && ctrl_out.bus_float && bus_clk_en_out
    |=> bus_grant_n_out == $past(req_d2_reg)) else $error("hold sample wrong");
  chk_resume_delay: assert property ($rose(bus_grant_n_out) && bus_clk_en_out |-> resume_step)
    else $error("resume delay wrong");
  chk_pause_freeze: assert property (!bus_clk_en_out |=>
    $stable(bus_grant_n_out) && $stable(ctrl_out)) else $error("moved while paused");
  chk_clk_enable: assert property (bus_clk_en_out ==
    !(ready_state_in || stop_instruction_in || wait_instruction_in)) else $error("clock enable wrong");
  chk_watchdog_halt: assert property (ctrl_out.watchdog_halt == ctrl_out.cpu_clk_stop)
    else $error("watchdog halt wrong");
  chk_addr_repeat: assert property ($fell(bus_grant_n_out) |->
    ctrl_out.addr_repeat == $past(bus_status_in.cycle_active)) else $error("address repeat wrong");
endmodule // bhg_monitor
bind bhg_top bhg_monitor bhg_monitor_inst (.*);
`default_nettype wire

/* test/bhg_master_model.sv */
// Outside bus master that asks for and uses the bus
`timescale 1ns/1ps
`default_nettype none
module bhg_master_model (
  input  wire logic clk_in,     // Clock
  input  wire logic grant_n_in, // Grant pin
  input  wire logic want_in,    // Bus wanted
  output var  logic req_n_out,  // Request pin
  output var  logic drive_out   // Driving the shared bus
);
  logic granted_reg;
  initial begin
    req_n_out   = 1'h1;
    drive_out   = 1'h0;
    granted_reg = 1'h0;
  end
  always @(negedge clk_in) begin
    granted_reg <= !grant_n_in;
    drive_out   <= want_in && !grant_n_in && granted_reg;
    if (want_in) req_n_out <= 1'h0;
    else if (!drive_out) req_n_out <= 1'h1;
  end
endmodule // bhg_master_model
`default_nettype wire

/* test/bus_hold_grant_handshake_tb.sv */
// Self-checking bench for the bus hold grant block
`timescale 1ns/1ps
`default_nettype none
module bus_hold_grant_handshake_tb;
  // ==========================================================================
  // Signals
  // ==========================================================================
  logic                        ref_clk_in    = 1'h0;
  logic                        rst_in        = 1'h1;
  logic                        want          = 1'h0;
  logic [2:0]                  pause         = 3'h0;
  bhg_pkg::bhg_bus_status_type bus_status_in = 3'h0;
  wire logic                   ready_state_in      = pause[2];
  wire logic                   stop_instruction_in = pause[1];
  wire logic                   wait_instruction_in = pause[0];
  wire logic                   bus_request_n_in;
  logic                        bus_clk_en_out, bus_grant_n_out, drive;
  logic                        rw_oe_out, byte_high_enable_n_oe_out, addr_data_oe_out;
  bhg_pkg::bhg_ctrl_type       ctrl_out;
  int unsigned                 cyc = 0, checks = 0, mismatches = 0, p;
  logic                        last_g = 1'h1;
  logic [33:0]                 notes[$];

  bhg_top bhg_top_inst (.*);
  bhg_master_model bhg_master_model_inst (.clk_in(ref_clk_in), .grant_n_in(bus_grant_n_out),
    .want_in(want), .req_n_out(bus_request_n_in), .drive_out(drive));

  always #12.5 ref_clk_in = ~ref_clk_in;
  always @(posedge ref_clk_in) begin
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      mismatches++;
      wrap_up();
    end
  end
  // ==========================================================================
  // Tasks
  // ==========================================================================
  task automatic check(input logic [33:0] seen, input logic [33:0] exp);
    checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wrap_up;
    $display("Checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // Notes hold grant level, address repeat and the cycle of the grant change
  task automatic hold(input int unsigned len, input logic ar, input int unsigned lat);
    notes.push_back({1'h0, ar, cyc + lat});
    want <= 1'h1;
    repeat (lat + len) @(negedge ref_clk_in);
    notes.push_back({1'h1, 1'h0, cyc + 32'h5});
    want <= 1'h0;
    repeat (8) @(negedge ref_clk_in);
  endtask
  // ==========================================================================
  // Watcher
  // ==========================================================================
  always @(negedge ref_clk_in) begin
    if (!rst_in && drive) check({33'h0, addr_data_oe_out}, 34'h0);
    if (!rst_in && bus_grant_n_out !== last_g) begin
      last_g = bus_grant_n_out;
      if (bus_grant_n_out) check({33'h0, addr_data_oe_out}, 34'h0);
      if (notes.size() == 0) check(34'h1, 34'h0);
      else check({bus_grant_n_out, ~bus_grant_n_out & ctrl_out.addr_repeat, cyc}, notes.pop_front());
    end
  end
  // ==========================================================================
  // Main sequence
  // ==========================================================================
  initial begin
    void'($urandom(8516));
    repeat (4) @(negedge ref_clk_in);
    rst_in <= 1'h0;
    check({26'h0, bus_grant_n_out, ctrl_out, rw_oe_out, byte_high_enable_n_oe_out, addr_data_oe_out}, 34'h87);
    repeat (3) @(negedge ref_clk_in);
    repeat (4) hold($urandom_range(9, 2), 1'h0, 4);
    fork
      hold(3, 1'h1, 8);
      begin
        bus_status_in <= 3'h4;
        repeat (5) @(negedge ref_clk_in);
        bus_status_in <= 3'h7;
        @(negedge ref_clk_in);
        bus_status_in <= 3'h4;
        @(negedge ref_clk_in);
        bus_status_in <= 3'h6;
        @(negedge ref_clk_in);
        bus_status_in <= 3'h0;
      end
    join
    for (int i = 0; i < 3; i++) begin
      p = $urandom_range(4, 1);
      fork
        hold(3, 1'h0, 4 + p);
        begin
          repeat (3) @(negedge ref_clk_in);
          pause <= 3'h4 >> i;
          repeat (p) begin
            @(negedge ref_clk_in);
            check({33'h0, bus_clk_en_out}, 34'h0);
          end
          pause <= 3'h0;
        end
      join
    end
    check({2'h0, notes.size()}, 34'h0);
    wrap_up();
  end
endmodule // bus_hold_grant_handshake_tb
`default_nettype wire
